// ### inc/rsi_pkg.sv
// What this block does
// RULE1 - one of three restart modes active
// RULE2 - no interlock: restart once field clears
// RULE3 - delay 2..60 s of clear field
// RULE4 - interlock: off on entry, stay off
// RULE5 - interlock: only reset switch restarts
// RULE6 - reset with clear field: outputs on, green
// RULE7 - interlock on outputs, not raw field status
// RULE8 - machine restarts only after scanner reset
// RULE9 - five pins: two inputs, three outputs
// RULE10 - output is OR of selected sources
// RULE11 - linked: partner field sources selectable too
// RULE12 - input C takes pins 1 and 5
// RULE13 - compatibility mode: fixed pin roles
// RULE14 - diagnostic output: off, contam, error, both
// RULE15 - field set count depends on variant
// RULE16 - contactor check before restart, fault locks (in interlock mode the fault only holds outputs off)
// RULE17 - reset while field occupied is ignored
// RULE18 - reset required while held off, field clear
//
// package with register map, field positions and types for the restart block
// assumes a 20 MHz system clock and a 32-bit classic wishbone master
package rsi_pkg;
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ * TICK_S;
  localparam logic [5:0] DELAY_MIN_S = 6'H02;
  localparam logic [5:0] DELAY_MAX_S = 6'H3C;
  localparam int unsigned FIELD_SETS_DEF = 16;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'H00;
  localparam logic [7:0] ADDR_DELAY = 8'H04;
  localparam logic [7:0] ADDR_SEL3 = 8'H08;
  localparam logic [7:0] ADDR_SEL4 = 8'H0C;
  localparam logic [7:0] ADDR_SEL5 = 8'H10;
  localparam logic [7:0] ADDR_STATUS = 8'H14;
  localparam logic [7:0] ADDR_FIELD = 8'H18;
  // control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_EDM = 2;
  localparam int unsigned CTRL_P2_RESET = 3;
  localparam int unsigned CTRL_IN_C = 4;
  localparam int unsigned CTRL_COMPAT = 5;
  localparam int unsigned CTRL_LINKED = 6;
  localparam int unsigned CTRL_DUAL = 7;
  localparam int unsigned CTRL_DIAG_LSB = 8;
  localparam logic [9:0] CTRL_RST = 10'H002;
  localparam logic [10:0] SEL_RST = 11'H000;
  // output source indices
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned SRC_ERROR = 0;
  localparam int unsigned SRC_CONTAM_ERR = 1;
  localparam int unsigned SRC_CONTAM_WARN = 2;
  localparam int unsigned SRC_WARN1 = 3;
  localparam int unsigned SRC_WARN2 = 4;
  localparam int unsigned SRC_RESET_REQ = 5;
  localparam int unsigned SRC_P_PF = 6;
  localparam int unsigned SRC_P_W1 = 7;
  localparam int unsigned SRC_P_W2 = 8;
  localparam int unsigned SRC_P_SIM_PF = 9;
  localparam int unsigned SRC_P_SIM_WF = 10;
  typedef enum logic [1:0] {RSI_MODE_NONE, RSI_MODE_DELAY, RSI_MODE_INTERLOCK, RSI_MODE_SPARE}
    rsi_mode_t;
  typedef enum logic [1:0] {RSI_DIAG_OFF, RSI_DIAG_CONTAM, RSI_DIAG_ERROR, RSI_DIAG_BOTH}
    rsi_diag_t;
endpackage

// ### inc/rsi_src_if.sv
// interface carrying output sources and pin configuration to the pin mapper
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface rsi_src_if;
  import rsi_pkg::*;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] sel3;
  logic [NUM_SRC-1:0] sel4;
  logic [NUM_SRC-1:0] sel5;
  logic compat;
  logic linked;
  logic dual;
  logic in_c;
  rsi_diag_t diag;
  modport ctrl (output src, sel3, sel4, sel5, compat, linked, dual, in_c, diag);
  modport map (input src, sel3, sel4, sel5, compat, linked, dual, in_c, diag);
endinterface
`default_nettype wire

// ### rtl/rsi_pin_map.sv
// general pin output mapper: selects and ORs status sources onto pins 3..5
// assumes sources come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module rsi_pin_map
  import rsi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  rsi_src_if.map src_if,
  output logic o_general_pin_3,
  output logic o_general_pin_4,
  output logic o_general_pin_5
);
  typedef struct packed {
    logic p3;
    logic p4;
    logic p5;
  } rsi_map_regs_t;
  rsi_map_regs_t r_q, r_d;
  logic [NUM_SRC-1:0] avail;
  logic diag;

  // partner sources only when linked, simultaneous ones only in dual-field mode
  always_comb
  begin
    avail = src_if.src;
    if (!src_if.linked)
    begin
      avail[SRC_P_W2:SRC_P_PF] = 3'H0; // [RULE11]
    end
    if (!(src_if.linked && src_if.dual))
    begin
      avail[SRC_P_SIM_WF:SRC_P_SIM_PF] = 2'H0; // [RULE11]
    end
    unique case (src_if.diag) // [RULE14]
      RSI_DIAG_OFF: diag = 1'b0;
      RSI_DIAG_CONTAM: diag = src_if.src[SRC_CONTAM_ERR] | src_if.src[SRC_CONTAM_WARN];
      RSI_DIAG_ERROR: diag = src_if.src[SRC_ERROR];
      RSI_DIAG_BOTH: diag = src_if.src[SRC_ERROR] | src_if.src[SRC_CONTAM_ERR]
        | src_if.src[SRC_CONTAM_WARN];
    endcase
  end

  // compatibility roles are fixed; otherwise each pin ORs its selection
  always_comb
  begin
    r_d = r_q;
    if (src_if.compat)
    begin
      r_d.p3 = diag; // [RULE13]
      r_d.p4 = src_if.src[SRC_WARN1]; // [RULE13]
      r_d.p5 = src_if.src[SRC_RESET_REQ]; // [RULE13]
    end
    else
    begin
      r_d.p3 = |(avail & src_if.sel3); // [RULE10]
      r_d.p4 = |(avail & src_if.sel4); // [RULE10]
      r_d.p5 = |(avail & src_if.sel5); // [RULE10]
    end
    if (src_if.in_c)
    begin
      r_d.p5 = 1'b0; // pin 5 belongs to input C [RULE12]
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_general_pin_3 = r_q.p3;
  assign o_general_pin_4 = r_q.p4;
  assign o_general_pin_5 = r_q.p5;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_pin5_input_c: assert property (src_if.in_c |=> !o_general_pin_5) // [RULE12]
    else $error("pin 5 driven while input C in use");
  a_compat_warn: assert property (src_if.compat |=> o_general_pin_4 == $past(src_if.src[SRC_WARN1])) // [RULE13]
    else $error("compat warning output wrong");
  a_or_select: assert property (!src_if.compat && (avail & src_if.sel3) != '0 |=> o_general_pin_3) // [RULE10]
    else $error("selected source not seen on pin 3");
  c_compat_diag: cover property (src_if.compat && diag ##1 o_general_pin_3);
endmodule
`default_nettype wire

// ### rtl/rsi_restart_top.sv
// restart interlock, restart delay and contactor check for the safety outputs
// assumes field and status inputs come from scanner logic on i_clock,
// pins 1 and 2 are asynchronous and registers sit on a classic wishbone bus
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rsi_restart_top
  import rsi_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = rsi_pkg::TICK_CYCLES,
  parameter int unsigned P_FIELD_SETS = rsi_pkg::FIELD_SETS_DEF
)
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_field_clear,
  input wire logic i_warn1,
  input wire logic i_warn2,
  input wire logic i_error,
  input wire logic i_contam_err,
  input wire logic i_contam_warn,
  input wire logic i_partner_pf,
  input wire logic i_partner_w1,
  input wire logic i_partner_w2,
  input wire logic i_partner_sim_pf,
  input wire logic i_partner_sim_wf,
  input wire logic i_general_pin_1,
  input wire logic i_general_pin_2,
  output logic o_general_pin_3,
  output logic o_general_pin_4,
  output logic o_general_pin_5,
  output logic o_safety_switching_output,
  output logic o_led_green,
  output logic o_reset_required,
  output logic [3:0] o_field_set
);
  typedef enum logic [2:0] {ST_ON, ST_OFF, ST_WAIT, ST_HOLD, ST_LOCK} rsi_state_t;
  typedef struct packed {
    rsi_state_t st;
    logic [9:0] ctrl;
    logic [5:0] delay;
    logic [10:0] sel3;
    logic [10:0] sel4;
    logic [10:0] sel5;
    logic [3:0] fset;
    logic [1:0] p1_s;
    logic [1:0] p2_s;
    logic p1_prev;
    logic p2_prev;
    logic [31:0] div;
    logic [5:0] secs;
    logic edm_fault;
    logic ack;
    logic [31:0] dat;
  } rsi_regs_t;

  rsi_regs_t r_q, r_d;
  rsi_mode_t mode;
  logic mode_hold;
  logic rst_pulse;
  logic fb_ok;
  logic tick;
  logic wr_ack;
  logic [31:0] wv;
  logic [31:0] rd;
  rsi_src_if src_if ();

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wr,
    input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // clamp a delay figure into the permitted span of seconds
  function automatic logic [5:0] clamp_delay(input logic [5:0] v);
    if (v < DELAY_MIN_S)
    begin
      return DELAY_MIN_S;
    end
    if (v > DELAY_MAX_S)
    begin
      return DELAY_MAX_S;
    end
    return v;
  endfunction

  // mode decode: the spare code acts as interlock, the safest reading
  assign mode = rsi_mode_t'(r_q.ctrl[CTRL_MODE_LSB +: 2]); // [RULE1]
  assign mode_hold = (mode == RSI_MODE_INTERLOCK) || (mode == RSI_MODE_SPARE); // [RULE1]

  // reset switch: pin 1 unless input C owns it, pin 2 when set as reset and not feedback
  assign rst_pulse = (r_q.p1_s[1] && !r_q.p1_prev && !r_q.ctrl[CTRL_IN_C]) // [RULE9] [RULE12]
    || (r_q.p2_s[1] && !r_q.p2_prev && r_q.ctrl[CTRL_P2_RESET] && !r_q.ctrl[CTRL_EDM]);
  // feedback high means both contactors have dropped out
  assign fb_ok = !r_q.ctrl[CTRL_EDM] || r_q.p2_s[1]; // [RULE16]
  assign tick = (r_q.div == 32'(P_TICK_CYCLES - 1));
  assign wr_ack = i_wb_cyc && i_wb_stb && i_wb_we && r_q.ack;

  // read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (i_wb_adr)
      ADDR_CTRL: rd = {22'H000000, r_q.ctrl};
      ADDR_DELAY: rd = {26'H0000000, r_q.delay};
      ADDR_SEL3: rd = {21'H000000, r_q.sel3};
      ADDR_SEL4: rd = {21'H000000, r_q.sel4};
      ADDR_SEL5: rd = {21'H000000, r_q.sel5};
      // raw field status beside the output status, which carries the interlock
      ADDR_STATUS: rd = {25'H0000000, r_q.p2_s[1], r_q.p1_s[1], (r_q.st == ST_LOCK),
        r_q.edm_fault, (r_q.st == ST_HOLD), i_field_clear, (r_q.st == ST_ON)}; // [RULE7]
      ADDR_FIELD: rd = {28'H0000000, r_q.fset};
      default: rd = 32'H00000000;
    endcase
  end

  // register file, synchronisers and the restart state machine
  always_comb
  begin
    wv = 32'H00000000;
    r_d = r_q;
    r_d.ack = i_wb_cyc && i_wb_stb && !r_q.ack;
    if (i_wb_cyc && i_wb_stb && !r_q.ack)
    begin
      r_d.dat = rd;
    end
    if (wr_ack)
    begin
      unique case (i_wb_adr)
        ADDR_CTRL:
        begin
          wv = wb_merge({22'H000000, r_q.ctrl}, i_wb_dat, i_wb_sel);
          r_d.ctrl = wv[9:0];
        end
        ADDR_DELAY:
        begin
          wv = wb_merge({26'H0000000, r_q.delay}, i_wb_dat, i_wb_sel);
          r_d.delay = clamp_delay(wv[5:0]); // [RULE3]
        end
        ADDR_SEL3:
        begin
          wv = wb_merge({21'H000000, r_q.sel3}, i_wb_dat, i_wb_sel);
          r_d.sel3 = wv[10:0];
        end
        ADDR_SEL4:
        begin
          wv = wb_merge({21'H000000, r_q.sel4}, i_wb_dat, i_wb_sel);
          r_d.sel4 = wv[10:0];
        end
        ADDR_SEL5:
        begin
          wv = wb_merge({21'H000000, r_q.sel5}, i_wb_dat, i_wb_sel);
          r_d.sel5 = wv[10:0];
        end
        ADDR_FIELD:
        begin
          wv = wb_merge({28'H0000000, r_q.fset}, i_wb_dat, i_wb_sel);
          if (wv < P_FIELD_SETS) // sets beyond this variant are refused [RULE15]
          begin
            r_d.fset = wv[3:0];
          end
        end
        default:
        begin
          wv = 32'H00000000;
        end
      endcase
    end
    // two-stage synchronisers; only stage one feeds stage two
    r_d.p1_s = {r_q.p1_s[0], i_general_pin_1}; // [RULE9]
    r_d.p2_s = {r_q.p2_s[0], i_general_pin_2}; // [RULE9]
    r_d.p1_prev = r_q.p1_s[1];
    r_d.p2_prev = r_q.p2_s[1];
    // second divider runs only while a delay is being timed
    r_d.div = (r_q.st == ST_WAIT && !tick) ? r_q.div + 32'H00000001 : 32'H00000000;
    unique case (r_q.st)
      ST_ON:
      begin
        if (!i_field_clear)
        begin
          r_d.st = ST_OFF; // [RULE4]
        end
      end
      ST_OFF:
      begin
        // a reset switch press here is ignored by construction [RULE17]
        if (i_field_clear)
        begin
          if (mode_hold)
          begin
            r_d.st = ST_HOLD; // [RULE4]
          end
          else if (mode == RSI_MODE_DELAY)
          begin
            r_d.st = ST_WAIT;
            r_d.secs = r_q.delay; // [RULE3]
          end
          else if (fb_ok)
          begin
            r_d.st = ST_ON; // immediate restart [RULE2]
          end
          else
          begin
            r_d.st = ST_LOCK; // [RULE16]
            r_d.edm_fault = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (!i_field_clear)
        begin
          r_d.st = ST_OFF; // occupation restarts the full delay [RULE3]
        end
        else if (tick)
        begin
          r_d.secs = r_q.secs - 6'H01;
          if (r_q.secs == 6'H01)
          begin
            r_d.st = fb_ok ? ST_ON : ST_LOCK; // [RULE3] [RULE16]
            r_d.edm_fault = !fb_ok;
          end
        end
      end
      ST_HOLD:
      begin
        if (!i_field_clear)
        begin
          r_d.st = ST_OFF;
        end
        else if (rst_pulse)
        begin
          // in interlock mode a contactor fault only keeps outputs off
          r_d.st = fb_ok ? ST_ON : ST_HOLD; // [RULE5] [RULE6] [RULE16]
          r_d.edm_fault = !fb_ok;
        end
      end
      ST_LOCK:
      begin
        r_d.st = ST_LOCK; // lock-out ends only with a device reset [RULE16]
      end
      default:
      begin
        r_d.st = ST_LOCK;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      r_q <= '0;
      r_q.st <= ST_OFF;
      r_q.ctrl <= CTRL_RST;
      r_q.delay <= DELAY_MIN_S;
      r_q.sel3 <= SEL_RST;
      r_q.sel4 <= SEL_RST;
      r_q.sel5 <= SEL_RST;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // outputs decoded from state flip-flops
  assign o_safety_switching_output = (r_q.st == ST_ON); // [RULE7]
  assign o_led_green = (r_q.st == ST_ON); // [RULE6]
  assign o_reset_required = (r_q.st == ST_HOLD); // [RULE18]
  assign o_field_set = r_q.fset;
  assign o_wb_ack = r_q.ack;
  assign o_wb_dat = r_q.dat;

  // sources and configuration for the pin mapper
  assign src_if.src = {i_partner_sim_wf, i_partner_sim_pf, i_partner_w2, i_partner_w1,
    i_partner_pf, (r_q.st == ST_HOLD), i_warn2, i_warn1, i_contam_warn, i_contam_err,
    i_error}; // [RULE10] [RULE11]
  assign src_if.sel3 = r_q.sel3;
  assign src_if.sel4 = r_q.sel4;
  assign src_if.sel5 = r_q.sel5;
  assign src_if.compat = r_q.ctrl[CTRL_COMPAT];
  assign src_if.linked = r_q.ctrl[CTRL_LINKED];
  assign src_if.dual = r_q.ctrl[CTRL_DUAL];
  assign src_if.in_c = r_q.ctrl[CTRL_IN_C];
  assign src_if.diag = rsi_diag_t'(r_q.ctrl[CTRL_DIAG_LSB +: 2]);

  rsi_pin_map u_pin_map (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .src_if(src_if),
    .o_general_pin_3(o_general_pin_3),
    .o_general_pin_4(o_general_pin_4),
    .o_general_pin_5(o_general_pin_5)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_none_restart: assert property (mode == RSI_MODE_NONE && r_q.st == ST_OFF && i_field_clear
    && fb_ok |=> o_safety_switching_output) // [RULE2]
    else $error("no immediate restart without interlock");
  a_occupied_off: assert property (o_safety_switching_output && !i_field_clear
    |=> !o_safety_switching_output) // [RULE4]
    else $error("outputs stayed on with field occupied");
  a_hold_stays_off: assert property (r_q.st == ST_HOLD && !rst_pulse
    |=> !o_safety_switching_output) // [RULE4]
    else $error("interlock released without reset");
  a_reset_restart: assert property (r_q.st == ST_HOLD && i_field_clear && rst_pulse && fb_ok
    |=> o_safety_switching_output && o_led_green) // [RULE6]
    else $error("reset with clear field did not restart");
  a_delay_span: assert property (r_q.delay >= DELAY_MIN_S && r_q.delay <= DELAY_MAX_S) // [RULE3]
    else $error("restart delay out of span");
  a_wait_off: assert property (r_q.st == ST_WAIT |-> !o_safety_switching_output) // [RULE3]
    else $error("outputs on during restart delay");
  a_occupied_reset: assert property (r_q.st == ST_OFF && rst_pulse && !i_field_clear
    |=> !o_safety_switching_output) // [RULE17]
    else $error("reset honoured with field occupied");
  a_rr_cleared: assert property ($rose(o_safety_switching_output) |-> !o_reset_required) // [RULE18]
    else $error("reset required still set with outputs on");
  a_lock_stays: assert property (r_q.st == ST_LOCK |=> r_q.st == ST_LOCK
    && !o_safety_switching_output) // [RULE16]
    else $error("lock-out left without device reset");
  a_fset_limit: assert property (r_q.fset < P_FIELD_SETS) // [RULE15]
    else $error("field set beyond variant count");
  c_interlock_cycle: cover property (r_q.st == ST_HOLD ##[1:50] o_safety_switching_output);
  c_delay_done: cover property (r_q.st == ST_WAIT ##1 o_safety_switching_output);
  c_lockout: cover property (r_q.st == ST_LOCK);
endmodule
`default_nettype wire

// ### dv/rsi_machine_model.sv
// machine side model: operator reset switch, contactors, machine restart switch
// assumes the bench requests presses with one-cycle pulses on the block clock
`timescale 1ns/100ps
`default_nettype none
module rsi_machine_model (
  input wire logic i_clock,
  input wire logic i_ssw,
  input wire logic i_press,
  input wire logic i_weld,
  input wire logic i_start,
  output logic o_general_pin_1,
  output logic o_general_pin_2,
  output logic o_machine_run
);
  int hold_cnt = 0;
  // quiet levels before the first edge
  initial
  begin
    o_general_pin_1 = 1'b0;
    o_general_pin_2 = 1'b1;
    o_machine_run = 1'b0;
  end
  // switch held several cycles so the two-stage synchroniser surely sees it
  always @(posedge i_clock)
  begin
    hold_cnt <= i_press ? 4 : (hold_cnt > 0 ? hold_cnt - 1 : 0);
    o_general_pin_1 <= i_press || hold_cnt > 1;
  end
  // contactors release when de-energised; a welded one never does
  always @(posedge i_clock)
    o_general_pin_2 <= !i_ssw && !i_weld;
  // machine runs only with the scanner on, then its own start switch
  always @(posedge i_clock)
    o_machine_run <= i_ssw && (o_machine_run || i_start);
endmodule
`default_nettype wire

// ### dv/restart_interlock_and_universal_pins_tb.sv
// self-checking bench: wishbone tasks, restart scenarios, pin mapping model
// assumes a short one-second tick so delay mode finishes in tens of cycles
`timescale 1ns/100ps
`default_nettype none
module restart_interlock_and_universal_pins_tb;
  import rsi_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'H00;
  logic [3:0] sel = 4'H0;
  logic [31:0] wdat = 32'H0;
  logic [31:0] rdat;
  logic ack;
  logic fclr = 1'b1;
  logic [10:0] st = 11'H000;
  logic press = 1'b0;
  logic weld = 1'b0;
  logic start = 1'b0;
  logic pin1, pin2, p3, p4, p5, ssw, led, rr, mrun;
  logic [3:0] fs;
  int error_cnt = 0;
  int comparisons = 0;

  rsi_restart_top #(.P_TICK_CYCLES(10), .P_FIELD_SETS(16)) i_dut (
    .i_clock(clock), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_field_clear(fclr), .i_warn1(st[3]),
    .i_warn2(st[4]), .i_error(st[0]), .i_contam_err(st[1]),
    .i_contam_warn(st[2]), .i_partner_pf(st[6]), .i_partner_w1(st[7]),
    .i_partner_w2(st[8]), .i_partner_sim_pf(st[9]), .i_partner_sim_wf(st[10]),
    .i_general_pin_1(pin1), .i_general_pin_2(pin2), .o_general_pin_3(p3),
    .o_general_pin_4(p4), .o_general_pin_5(p5), .o_safety_switching_output(ssw),
    .o_led_green(led), .o_reset_required(rr), .o_field_set(fs));
  rsi_machine_model i_machine (.i_clock(clock), .i_ssw(ssw), .i_press(press),
    .i_weld(weld), .i_start(start), .o_general_pin_1(pin1),
    .o_general_pin_2(pin2), .o_machine_run(mrun));

  // 20 MHz clock
  always #25 clock = ~clock;

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; ack and data are read pre-edge, so no race with the slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'HF;
    @(posedge clock);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) error_cnt++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'H0, q);
    check_word(nm, e, q);
  endtask
  // bounded wait for the safety output to reach a level
  task automatic wait_out(input logic e, input int n);
    int i;
    i = 0;
    @(posedge clock);
    while (ssw !== e && i < n)
    begin
      @(posedge clock);
      i++;
    end
    check_bit("safety_out", e, ssw);
  endtask
  task automatic hold_out(input logic e, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge clock);
      if (ssw !== e) bad = 1'b1;
    end
    check_bit("safety_out_held", 1'b0, bad);
  endtask
  task automatic pulse_press;
    @(posedge clock);
    press <= 1'b1;
    @(posedge clock);
    press <= 1'b0;
  endtask
  task automatic set_field(input logic v);
    @(posedge clock);
    fclr <= v;
  endtask
  // pin model: masked OR of sources, or the fixed compatibility roles
  function automatic logic [2:0] exp_pins(input int c, s3, s4, s5, s, r);
    int m;
    int src;
    logic [2:0] p;
    m = 32'H3F;
    if ((c >> 6) % 2 == 1) m = m | 32'H1C0;
    if ((c >> 6) % 4 == 3) m = m | 32'H600;
    src = (s & 32'H7DF) | (r << 5);
    p[0] = (src & s3 & m) != 0;
    p[1] = (src & s4 & m) != 0;
    p[2] = (src & s5 & m) != 0;
    if ((c >> 5) % 2 == 1)
    begin
      p[0] = ((c >> 8) % 2 == 1 && (s & 6) != 0) || ((c >> 9) % 2 == 1 && s % 2 == 1);
      p[1] = (s >> 3) % 2 == 1;
      p[2] = r != 0;
    end
    if ((c >> 4) % 2 == 1) p[2] = 1'b0;
    return p;
  endfunction

  // hang guard
  initial
  begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    finish_test();
  end

  // main sequence
  initial
  begin
    logic [31:0] q;
    logic [2:0] e;
    int c, s3, s4, s5;
    void'($urandom(56));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk("ctrl_rst", ADDR_CTRL, 32'H002);
    rd_chk("delay_rst", ADDR_DELAY, 32'H2);
    rd_chk("unmapped", 8'H1C, 32'H0);
    wr(ADDR_SEL5, 32'H20);
    repeat (3) @(posedge clock);
    check_bit("reset_req", 1'b1, rr);
    check_bit("pin5", 1'b1, p5);
    check_bit("safety_off", 1'b0, ssw);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    pulse_press();
    wait_out(1'b1, 10);
    check_bit("led", 1'b1, led);
    check_bit("reset_req_on", 1'b0, rr);
    check_bit("machine_early", 1'b0, mrun);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(posedge clock);
    check_bit("machine_run", 1'b1, mrun);
    set_field(1'b0);
    wait_out(1'b0, 4);
    pulse_press();
    hold_out(1'b0, 8);
    set_field(1'b1);
    hold_out(1'b0, 12);
    wb(1'b0, ADDR_STATUS, 32'H0, q);
    check_word("status", 32'H6, q & 32'H7);
    pulse_press();
    wait_out(1'b1, 10);
    // no interlock: clear field restarts at once
    wr(ADDR_CTRL, 32'H000);
    set_field(1'b0);
    wait_out(1'b0, 4);
    set_field(1'b1);
    wait_out(1'b1, 3);
    // delay: clamping, then an interrupted count must start over
    wr(ADDR_DELAY, 32'H1);
    rd_chk("delay_lo", ADDR_DELAY, 32'H2);
    wr(ADDR_DELAY, 32'H3F);
    rd_chk("delay_hi", ADDR_DELAY, 32'H3C);
    wr(ADDR_DELAY, 32'H3);
    wr(ADDR_CTRL, 32'H001);
    set_field(1'b0);
    wait_out(1'b0, 4);
    set_field(1'b1);
    hold_out(1'b0, 15);
    set_field(1'b0);
    set_field(1'b1);
    hold_out(1'b0, 28);
    wait_out(1'b1, 10);
    // random pin configurations and sources
    wr(ADDR_CTRL, 32'H000);
    for (int k = 0; k < 14; k++)
    begin
      c = $urandom & 32'H3F0;
      s3 = $urandom & 32'H7DF;
      s4 = $urandom & 32'H7DF;
      s5 = $urandom & 32'H7DF;
      wr(ADDR_CTRL, c);
      wr(ADDR_SEL3, s3);
      wr(ADDR_SEL4, s4);
      wr(ADDR_SEL5, s5);
      st <= 11'($urandom);
      repeat (3) @(posedge clock);
      e = exp_pins(c, s3, s4, s5, int'(st), 0);
      check_bit("pin3", e[0], p3);
      check_bit("pin4", e[1], p4);
      check_bit("pin5", e[2], p5);
    end
    // field set limit
    wr(ADDR_FIELD, 32'H5);
    wr(ADDR_FIELD, 32'H10);
    rd_chk("field", ADDR_FIELD, 32'H5);
    check_word("field_out", 32'H5, {28'H0, fs});
    wr(8'H1C, 32'HFFFF);
    rd_chk("unmapped_wr", 8'H1C, 32'H0);
    // contactor check: good restart, then a welded contactor locks out
    wr(ADDR_CTRL, 32'H004);
    set_field(1'b0);
    wait_out(1'b0, 4);
    // field stays occupied until the released contactors pass the synchroniser
    repeat (3) @(posedge clock);
    set_field(1'b1);
    wait_out(1'b1, 6);
    weld <= 1'b1;
    set_field(1'b0);
    wait_out(1'b0, 4);
    set_field(1'b1);
    hold_out(1'b0, 20);
    wb(1'b0, ADDR_STATUS, 32'H0, q);
    check_bit("lockout", 1'b1, q[4]);
    // only a device reset ends the lock-out; spare mode code acts as interlock
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    wr(ADDR_CTRL, 32'H007); // spare mode, contactor check on
    set_field(1'b0);
    set_field(1'b1);
    hold_out(1'b0, 6);
    check_bit("reset_req_spare", 1'b1, rr);
    // welded contactor: interlock mode only holds the outputs off
    pulse_press();
    hold_out(1'b0, 10);
    wb(1'b0, ADDR_STATUS, 32'H0, q);
    check_word("edm_hold", 32'HE, q & 32'H1F);
    weld <= 1'b0;
    pulse_press();
    wait_out(1'b1, 10);
    finish_test();
  end
endmodule
`default_nettype wire
